// *** omc_top.sv ***
// Function
// R1 - mode pin high at reset release selects normal run mode
// R2 - run mode starts at address read from vector bytes at top of memory
// R3 - background entered from pin low, halt command, halt instruction, breakpoints
// R4 - in background the processor is suspended and fetches nothing
// R5 - memory, status, debug register and halt commands accepted running or halted
// R6 - processor register, step and resume commands only in background mode
// R7 - resume command leaves background mode and continues the application
// R8 - wait instruction stops the processor clock
// R9 - entering wait clears the interrupt mask bit
// R10 - interrupt in wait wakes processor and starts stacking
// R11 - in wait only halt and status-memory commands are accepted
// R12 - status-memory commands in wait or stop return low-power error, no access
// R13 - halt command in wait wakes into background mode
// R14 - in wait system clocks run and regulator stays in full regulation
// R15 - in stop clocks stop, regulator standby, deep stop powers part down
// R16 - highest-priority enabled function drives a shared pin
// R17 - software should disable sharing modules before enabling another
// R18 - software should clear module flags after enabling alternate function
// R19 - timer external clocks route to timers one, two, three out of reset
// R20 - each debug link bit lasts sixteen debug controller clocks
// R21 - stop with stop option clear forces an illegal-opcode reset
// R22 - current mode is reported to the debug controller
module omc_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic mode_pin_in,
  input wire logic halt_instr,
  input wire logic ctrl_brk,
  input wire logic trace_brk,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic stop_enable_option,
  input wire logic deep_stop_sel,
  input wire logic irq_req,
  input wire logic wake_evt,
  input wire logic cmd_valid,
  input wire omc_pkg::omc_cmd_e cmd,
  input wire logic step_done,
  input wire logic [7:0] mem_rdata,
  input wire logic [5:0] tclk_route_wr,
  input wire logic tclk_route_we,
  input wire logic [2:0] tclk_in,
  input wire logic [2:0] alt1_en,
  input wire logic [2:0] alt2_en,
  input wire logic [2:0] port_out,
  input wire logic [2:0] alt1_out,
  input wire logic [2:0] alt2_out,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic [15:0] pc_load,
  output logic pc_load_en,
  output logic cpu_run,
  output logic cpu_clk_en,
  output logic imask_clear,
  output logic irq_stack,
  output logic sys_clk_en,
  output logic reg_full,
  output logic deep_pd,
  output logic illegal_reset,
  output logic cmd_accept,
  output logic cmd_error,
  output logic [7:0] status_data,
  output logic [1:0] cur_mode,
  output logic [2:0] timer_clk,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_n,
  output logic [3:0] bit_phase
);
  // ***********************************************************************
  // declarations
  // ***********************************************************************
  omc_pkg::omc_state_e state_q, state_d;
  logic mode_lvl;
  logic [2:0] settle_q;
  logic settled_w;
  logic [7:0] vec_hi_q;
  logic [15:0] pc_q;
  logic pc_en_q;
  logic illegal_q;
  logic [5:0] route_q;
  logic [7:0] stat_q;
  logic [3:0] phase_q;
  logic acc_w;
  logic nonintr_w;
  logic active_w;
  logic enter_bkgd_w;
  omc_cmd_if cif ();

  function automatic logic is_nonintr(input omc_pkg::omc_cmd_e c);
    return (c == omc_pkg::OMC_CMD_MEM) || (c == omc_pkg::OMC_CMD_MEM_STAT) ||
           (c == omc_pkg::OMC_CMD_DBG_REG) || (c == omc_pkg::OMC_CMD_HALT);
  endfunction

  function automatic logic [2:0] route_sel(input logic [5:0] r, input logic [2:0] t);
    logic [2:0] o;
    o = 3'h0;
    for (int i = 0; i < 3; i++) begin
      o[i] = t[r[2*i +: 2]];
    end
    return o;
  endfunction

  // ***********************************************************************
  // mode pin synchroniser
  // ***********************************************************************
  omc_pin_sync u_sync (
    .clock(clock),
    .rstn(rstn),
    .pin(mode_pin_in),
    .level(mode_lvl)
  );

  // ***********************************************************************
  // command gating by mode
  // ***********************************************************************
  assign cif.valid = cmd_valid;
  assign cif.cmd = cmd;
  assign nonintr_w = is_nonintr(cmd);
  assign active_w = (cmd == omc_pkg::OMC_CMD_CPU_REG) || (cmd == omc_pkg::OMC_CMD_STEP) ||
                    (cmd == omc_pkg::OMC_CMD_RESUME);
  // low-power modes take halt and status access only
  assign acc_w = cmd_valid && (
      ((state_q == omc_pkg::OMC_RUN) && nonintr_w) || // R5
      ((state_q == omc_pkg::OMC_BKGD) && (nonintr_w || active_w)) || // R6
      (((state_q == omc_pkg::OMC_WAIT) || (state_q == omc_pkg::OMC_STOP)) &&
       ((cmd == omc_pkg::OMC_CMD_HALT) || (cmd == omc_pkg::OMC_CMD_MEM_STAT)))); // R11
  assign cif.accept = acc_w;
  assign cif.error = acc_w && (cmd == omc_pkg::OMC_CMD_MEM_STAT) &&
                     ((state_q == omc_pkg::OMC_WAIT) || (state_q == omc_pkg::OMC_STOP)); // R12
  assign cmd_accept = cif.accept;
  assign cmd_error = cif.error;

  assign enter_bkgd_w = halt_instr || ctrl_brk || trace_brk ||
                        (acc_w && cmd == omc_pkg::OMC_CMD_HALT); // R3

  // ***********************************************************************
  // mode state machine
  // ***********************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      omc_pkg::OMC_RESET: begin
        // level settled through the synchroniser after reset release picks the mode
        if (settled_w) begin
          state_d = mode_lvl ? omc_pkg::OMC_VECT_LO : omc_pkg::OMC_BKGD; // R1
        end
      end
      omc_pkg::OMC_VECT_LO: state_d = omc_pkg::OMC_VECT_HI;
      omc_pkg::OMC_VECT_HI: state_d = omc_pkg::OMC_RUN; // R2
      omc_pkg::OMC_RUN: begin
        if (enter_bkgd_w) begin
          state_d = omc_pkg::OMC_BKGD; // R3
        end else if (wait_instr) begin
          state_d = omc_pkg::OMC_WAIT; // R8
        end else if (stop_instr && stop_enable_option) begin
          state_d = omc_pkg::OMC_STOP; // R15
        end
      end
      omc_pkg::OMC_BKGD: begin
        if (acc_w && cmd == omc_pkg::OMC_CMD_RESUME) begin
          state_d = omc_pkg::OMC_RUN; // R7
        end
      end
      omc_pkg::OMC_WAIT: begin
        if (acc_w && cmd == omc_pkg::OMC_CMD_HALT) begin
          state_d = omc_pkg::OMC_BKGD; // R13
        end else if (irq_req) begin
          state_d = omc_pkg::OMC_RUN; // R10
        end
      end
      omc_pkg::OMC_STOP: begin
        if (acc_w && cmd == omc_pkg::OMC_CMD_HALT) begin
          state_d = omc_pkg::OMC_BKGD;
        end else if (irq_req || wake_evt) begin
          state_d = omc_pkg::OMC_RUN;
        end
      end
      default: state_d = omc_pkg::OMC_RESET;
    endcase
  end

  // the synchroniser holds the pullup level in reset, so the pin only counts
  // once its level has crossed every stage and the agree compare
  assign settled_w = (settle_q == 3'(omc_pkg::SYNC_STAGES + 1));
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= omc_pkg::OMC_RESET;
      settle_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (!settled_w) begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  // ***********************************************************************
  // reset vector fetch
  // ***********************************************************************
  assign mem_addr = (state_q == omc_pkg::OMC_VECT_LO) ? omc_pkg::VECTOR_HI_ADDR :
                    omc_pkg::VECTOR_LO_ADDR;
  assign mem_rd = (state_q == omc_pkg::OMC_VECT_LO) || (state_q == omc_pkg::OMC_VECT_HI);

  // data arrives one cycle after the address: high byte first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vec_hi_q <= 8'h00;
      pc_q <= 16'h0000;
      pc_en_q <= 1'h0;
    end else begin
      pc_en_q <= (state_q == omc_pkg::OMC_VECT_HI); // R2
      if (state_q == omc_pkg::OMC_VECT_HI) begin
        vec_hi_q <= mem_rdata;
      end
      if (pc_en_q) begin
        pc_q <= {vec_hi_q, mem_rdata};
      end
    end
  end
  // the low byte is taken straight into the load value with the strobe
  assign pc_load = {vec_hi_q, mem_rdata};
  assign pc_load_en = pc_en_q;

  // ***********************************************************************
  // processor and power controls
  // ***********************************************************************
  assign cpu_run = (state_q == omc_pkg::OMC_RUN); // R4
  assign cpu_clk_en = (state_q == omc_pkg::OMC_RUN) || (state_q == omc_pkg::OMC_BKGD); // R8
  assign imask_clear = (state_q == omc_pkg::OMC_RUN) && (state_d == omc_pkg::OMC_WAIT); // R9
  assign irq_stack = (state_q == omc_pkg::OMC_WAIT) && (state_d == omc_pkg::OMC_RUN); // R10
  assign sys_clk_en = (state_q != omc_pkg::OMC_STOP); // R14
  assign reg_full = (state_q != omc_pkg::OMC_STOP); // R15
  assign deep_pd = (state_q == omc_pkg::OMC_STOP) && deep_stop_sel; // R15

  // illegal stop raises a reset request held until system reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      illegal_q <= 1'h0;
    end else if ((state_q == omc_pkg::OMC_RUN) && stop_instr && !stop_enable_option &&
                 !enter_bkgd_w && !wait_instr) begin
      illegal_q <= 1'h1; // R21
    end
  end
  assign illegal_reset = illegal_q;

  // ***********************************************************************
  // mode report and status byte
  // ***********************************************************************
  always_comb begin
    case (state_q)
      omc_pkg::OMC_WAIT: cur_mode = omc_pkg::OMC_MODE_WAIT;
      omc_pkg::OMC_STOP: cur_mode = omc_pkg::OMC_MODE_STOP;
      omc_pkg::OMC_BKGD: cur_mode = omc_pkg::OMC_MODE_BKGD;
      default: cur_mode = omc_pkg::OMC_MODE_RUN;
    endcase
  end // R22

  // low-power error replaces the memory byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stat_q <= 8'h00;
    end else if (acc_w && cmd == omc_pkg::OMC_CMD_MEM_STAT) begin
      stat_q <= cif.error ? omc_pkg::MEM_STAT_LOWPWR : mem_rdata; // R12
    end
  end
  assign status_data = stat_q;

  // ***********************************************************************
  // debug bit timing
  // ***********************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1; // R20
    end
  end
  assign bit_phase = phase_q;

  // ***********************************************************************
  // timer clock routing
  // ***********************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      route_q <= omc_pkg::TCLK_ROUTE_RST; // R19
    end else if (tclk_route_we) begin
      route_q <= tclk_route_wr;
    end
  end
  assign timer_clk = route_sel(route_q, tclk_in);

  // ***********************************************************************
  // shared pins
  // ***********************************************************************
  for (genvar g = 0; g < 3; g++) begin : g_pin
    omc_pin_mux u_mux (
      .port_out(port_out[g]),
      .port_oen_n(1'h0),
      .alt1_en(alt1_en[g]),
      .alt1_out(alt1_out[g]),
      .alt1_oen_n(1'h0),
      .alt2_en(alt2_en[g]),
      .alt2_out(alt2_out[g]),
      .alt2_oen_n(1'h0),
      .pin_out(pin_out[g]),
      .pin_oe_n(pin_oe_n[g]),
      .owner()
    );
  end

  // ***********************************************************************
  // checks
  // ***********************************************************************
  property p_run_sel;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_RESET && settled_w && mode_lvl) |=> state_q == omc_pkg::OMC_VECT_LO;
  endproperty
  a_run_sel: assert property (p_run_sel) else $error("pin high did not select run"); // R1

  property p_vec;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_VECT_LO) |=> ##1 pc_load_en ##1 cpu_run;
  endproperty
  a_vec: assert property (p_vec) else $error("vector fetch sequence wrong"); // R2

  property p_bkgd;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_RUN && (halt_instr || ctrl_brk || trace_brk))
      |=> cur_mode == omc_pkg::OMC_MODE_BKGD;
  endproperty
  a_bkgd: assert property (p_bkgd) else $error("background entry missed"); // R3

  property p_susp;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_BKGD) |-> !cpu_run;
  endproperty
  a_susp: assert property (p_susp) else $error("cpu runs in background"); // R4

  property p_active_only;
    @(posedge clock) disable iff (!rstn)
    (cmd_valid && cmd == omc_pkg::OMC_CMD_STEP && cur_mode != omc_pkg::OMC_MODE_BKGD)
      |-> !cmd_accept;
  endproperty
  a_active_only: assert property (p_active_only) else $error("step accepted outside"); // R6

  property p_resume;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_BKGD && cmd_valid && cmd == omc_pkg::OMC_CMD_RESUME)
      |=> cpu_run;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not run"); // R7

  property p_wait_cmd;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_WAIT && cmd_valid && cmd == omc_pkg::OMC_CMD_MEM) |-> !cmd_accept;
  endproperty
  a_wait_cmd: assert property (p_wait_cmd) else $error("memory command in wait"); // R11

  property p_wake_halt;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_WAIT && cmd_valid && cmd == omc_pkg::OMC_CMD_HALT)
      |=> cur_mode == omc_pkg::OMC_MODE_BKGD && sys_clk_en;
  endproperty
  a_wake_halt: assert property (p_wake_halt) else $error("halt did not wake"); // R13

  property p_illegal;
    @(posedge clock) disable iff (!rstn)
    (state_q == omc_pkg::OMC_RUN && stop_instr && !stop_enable_option && !wait_instr &&
     !halt_instr && !ctrl_brk && !trace_brk && !cmd_valid)
      |=> illegal_reset && cur_mode != omc_pkg::OMC_MODE_STOP;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal stop not trapped"); // R21

  c_wait: cover property (@(posedge clock) disable iff (!rstn)
    state_q == omc_pkg::OMC_WAIT ##1 state_q == omc_pkg::OMC_RUN);
  c_bkgd: cover property (@(posedge clock) disable iff (!rstn)
    state_q == omc_pkg::OMC_BKGD ##1 state_q == omc_pkg::OMC_RUN);
  c_err: cover property (@(posedge clock) disable iff (!rstn) cmd_error);
endmodule

// *** omc_pkg.sv ***
package omc_pkg;
  // ***********************************************************************
  // modes and commands
  // ***********************************************************************
  typedef enum logic [2:0] {
    OMC_RESET = 3'h0,
    OMC_VECT_LO = 3'h1,
    OMC_VECT_HI = 3'h2,
    OMC_RUN = 3'h3,
    OMC_BKGD = 3'h4,
    OMC_WAIT = 3'h5,
    OMC_STOP = 3'h6
  } omc_state_e;

  // mode indication to the debug controller
  typedef enum logic [1:0] {
    OMC_MODE_RUN = 2'h0,
    OMC_MODE_WAIT = 2'h1,
    OMC_MODE_STOP = 2'h2,
    OMC_MODE_BKGD = 2'h3
  } omc_mode_e;

  // debug command classes
  typedef enum logic [2:0] {
    OMC_CMD_MEM = 3'h0,
    OMC_CMD_MEM_STAT = 3'h1,
    OMC_CMD_DBG_REG = 3'h2,
    OMC_CMD_HALT = 3'h3,
    OMC_CMD_CPU_REG = 3'h4,
    OMC_CMD_STEP = 3'h5,
    OMC_CMD_RESUME = 3'h6,
    OMC_CMD_NONE = 3'h7
  } omc_cmd_e;

  // pin owner selection
  typedef enum logic [1:0] {
    OMC_OWN_PORT = 2'h0,
    OMC_OWN_ALT1 = 2'h1,
    OMC_OWN_ALT2 = 2'h2
  } omc_owner_e;

  localparam logic [15:0] VECTOR_HI_ADDR = 16'hfffe;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hffff;
  localparam int BIT_CYCLES = 16;
  localparam int SYNC_STAGES = 3;
  // timer clock routing after reset: input n feeds timer n
  localparam logic [5:0] TCLK_ROUTE_RST = 6'h24;
  localparam logic [7:0] MEM_STAT_LOWPWR = 8'hc0;
endpackage

// *** omc_cmd_if.sv ***
// command path from debug controller into the mode controller
interface omc_cmd_if;
  logic valid;
  omc_pkg::omc_cmd_e cmd;
  logic accept;
  logic error;
  modport ctrl (input valid, input cmd, output accept, output error);
  modport gate (output valid, output cmd, input accept, input error);
endinterface

// *** omc_pin_sync.sv ***
// ***********************************************************************
// three-stage pin synchroniser, change taken when stages two and three agree
// ***********************************************************************
module omc_pin_sync (
  input wire logic clock,
  input wire logic rstn,
  input wire logic pin,
  output logic level
);
  logic [2:0] sync_q;
  logic level_q;

  // reset value high matches the pin's pullup
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_q <= 3'h7;
      level_q <= 1'h1;
    end else begin
      sync_q <= {sync_q[1:0], pin};
      if (sync_q[1] == sync_q[2]) begin
        level_q <= sync_q[2];
      end
    end
  end
  assign level = level_q;
endmodule

// *** omc_pin_mux.sv ***
// ***********************************************************************
// pin owner selection: highest-priority enabled function drives the pin
// ***********************************************************************
module omc_pin_mux (
  input wire logic port_out,
  input wire logic port_oen_n,
  input wire logic alt1_en,
  input wire logic alt1_out,
  input wire logic alt1_oen_n,
  input wire logic alt2_en,
  input wire logic alt2_out,
  input wire logic alt2_oen_n,
  output logic pin_out,
  output logic pin_oe_n,
  output omc_pkg::omc_owner_e owner
);
  // alt2 over alt1 over port
  assign owner = alt2_en ? omc_pkg::OMC_OWN_ALT2 :
                 alt1_en ? omc_pkg::OMC_OWN_ALT1 : omc_pkg::OMC_OWN_PORT; // R16
  assign pin_out = alt2_en ? alt2_out : alt1_en ? alt1_out : port_out;
  assign pin_oe_n = alt2_en ? alt2_oen_n : alt1_en ? alt1_oen_n : port_oen_n;
endmodule

// *** omc_host_model.sv ***
// ***********************************************************************
// debug host on the single-wire mode pin
// ***********************************************************************
module omc_host_model (
  input wire logic clock,
  output logic mode_pin,
  output logic cmd_valid,
  output omc_pkg::omc_cmd_e cmd,
  input wire logic accept,
  input wire logic error
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hold_low;
  // pull-up on the pin: a released pin reads high, so run is the default
  assign mode_pin = hold_low ? 1'b0 : 1'b1;
  initial begin
    hold_low = 1'b0;
    cmd_valid = 1'b0;
    cmd = omc_pkg::OMC_CMD_NONE;
  end
  // one command, held from a falling edge through the taking edge
  task automatic issue(input omc_pkg::omc_cmd_e c, output logic acc, output logic err);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd = c;
    #4;
    acc = accept;
    err = error;
    @(negedge clock);
    cmd_valid = 1'b0;
    // released code lines show no stale value
    cmd = omc_pkg::omc_cmd_e'(~c);
  endtask
endmodule

// *** omc_top_tb.sv ***
module omc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rstn, mode_pin_in, halt_instr, ctrl_brk, trace_brk, wait_instr, stop_instr;
  logic stop_enable_option, deep_stop_sel, irq_req, wake_evt, cmd_valid, tclk_route_we;
  logic [7:0] mem_rdata, status_data;
  logic [5:0] tclk_route_wr;
  logic [2:0] tclk_in, alt1_en, alt2_en, port_out, alt1_out, alt2_out;
  logic [2:0] timer_clk, pin_out, pin_oe_n;
  logic [15:0] mem_addr, pc_load;
  logic mem_rd, pc_load_en, cpu_run, cpu_clk_en, imask_clear, irq_stack, sys_clk_en;
  logic reg_full, deep_pd, illegal_reset, cmd_accept, cmd_error, acc, err;
  logic [1:0] cur_mode;
  logic [3:0] bit_phase;
  omc_pkg::omc_cmd_e cmd;
  int fail_count, tests_run, cycles, n_imask, n_stack;

  // ***********************************************************************
  // clock, memory, pulse counters, hang guard
  // ***********************************************************************
  initial clock = 1'b0;
  always #5 clock = ~clock;
  // memory answers one cycle after the address, like a synchronous array
  always @(posedge clock) begin
    mem_rdata <= (mem_addr == 16'hfffe) ? 8'h12 : (mem_addr == 16'hffff) ? 8'h34 : 8'h5a;
    if (imask_clear === 1'b1) n_imask++;
    if (irq_stack === 1'b1) n_stack++;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  omc_host_model u_host (.clock(clock), .mode_pin(mode_pin_in), .cmd_valid(cmd_valid),
    .cmd(cmd), .accept(cmd_accept), .error(cmd_error));

  omc_top u_dut (.clock(clock), .rstn(rstn), .mode_pin_in(mode_pin_in),
    .halt_instr(halt_instr), .ctrl_brk(ctrl_brk), .trace_brk(trace_brk),
    .wait_instr(wait_instr), .stop_instr(stop_instr), .stop_enable_option(stop_enable_option),
    .deep_stop_sel(deep_stop_sel), .irq_req(irq_req), .wake_evt(wake_evt),
    .cmd_valid(cmd_valid), .cmd(cmd), .step_done(1'b0), .mem_rdata(mem_rdata),
    .tclk_route_wr(tclk_route_wr), .tclk_route_we(tclk_route_we), .tclk_in(tclk_in),
    .alt1_en(alt1_en), .alt2_en(alt2_en), .port_out(port_out), .alt1_out(alt1_out),
    .alt2_out(alt2_out), .mem_addr(mem_addr), .mem_rd(mem_rd), .pc_load(pc_load),
    .pc_load_en(pc_load_en), .cpu_run(cpu_run), .cpu_clk_en(cpu_clk_en),
    .imask_clear(imask_clear), .irq_stack(irq_stack), .sys_clk_en(sys_clk_en),
    .reg_full(reg_full), .deep_pd(deep_pd), .illegal_reset(illegal_reset),
    .cmd_accept(cmd_accept), .cmd_error(cmd_error), .status_data(status_data),
    .cur_mode(cur_mode), .timer_clk(timer_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .bit_phase(bit_phase));

  // ***********************************************************************
  // shared tasks
  // ***********************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    step(2);
  endtask
  // reset held 16 cycles; the pin level is set well before release
  task automatic do_reset(input logic pin_low);
    @(negedge clock);
    u_host.hold_low = pin_low;
    rstn = 1'b0;
    step(16);
    rstn = 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ***********************************************************************
  // scenarios
  // ***********************************************************************
  task automatic t_vector;
    do_reset(1'b0);
    for (int i = 0; i < 20 && pc_load_en !== 1'b1; i++) begin
      if (mem_rd === 1'b1) check(mem_addr[15:1], 15'h7fff);
      @(negedge clock);
    end
    check(pc_load_en, 1);
    check(pc_load, 16'h1234);
    check(cur_mode, omc_pkg::OMC_MODE_RUN);
    check(cpu_run, 1);
  endtask
  task automatic t_timers;
    for (int i = 0; i < 8; i++) begin
      tclk_in = 3'(i);
      #1 check(timer_clk, tclk_in);
      @(negedge clock);
    end
    tclk_route_wr = 6'h12;
    tclk_route_we = 1'b1;
    @(negedge clock);
    tclk_route_we = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tclk_in = 3'(i);
      #1 check(timer_clk, {tclk_in[1], tclk_in[0], tclk_in[2]});
      @(negedge clock);
    end
  endtask
  // every enable mix, two data patterns so all three sources tell apart;
  // owners change only from all-off and no module interrupt is ever armed
  task automatic t_pins;
    port_out = 3'h0;
    for (int p = 0; p < 2; p++) begin
      alt1_out = p ? 3'h0 : 3'h7;
      alt2_out = p ? 3'h7 : 3'h0;
      for (int k = 0; k < 64; k++) begin
        alt1_en = 3'h0;
        alt2_en = 3'h0;
        @(negedge clock);
        {alt1_en, alt2_en} = 6'(k);
        #1 check(pin_out, (alt2_en & alt2_out) | (~alt2_en & alt1_en & alt1_out)
          | (~alt2_en & ~alt1_en & port_out));
        check(pin_oe_n, 3'h0);
      end
    end
  endtask
  task automatic t_phase;
    logic [3:0] prev;
    for (int i = 0; i < 20; i++) begin
      prev = bit_phase;
      @(negedge clock);
      check(bit_phase, 4'(prev + 4'h1));
    end
  endtask
  // run mode: only non-intrusive commands, then every way into background
  task automatic t_run_cmds;
    for (int k = 0; k < 7; k++) begin
      if (k == 3) continue;
      u_host.issue(omc_pkg::omc_cmd_e'(k), acc, err);
      check(acc, k < 3);
    end
    for (int s = 0; s < 4; s++) begin
      if (s == 0) u_host.issue(omc_pkg::OMC_CMD_HALT, acc, err);
      else begin
        @(negedge clock);
        {trace_brk, ctrl_brk, halt_instr} = 3'h1 << (s - 1);
        @(negedge clock);
        {trace_brk, ctrl_brk, halt_instr} = 3'h0;
      end
      step(2);
      check(cur_mode, omc_pkg::OMC_MODE_BKGD);
      check({cpu_run, mem_rd}, 0);
      u_host.issue(omc_pkg::OMC_CMD_RESUME, acc, err);
      check({acc, cur_mode, cpu_run}, {1'b1, omc_pkg::OMC_MODE_RUN, 1'b1});
    end
  endtask
  task automatic t_wait;
    int ni;
    int ns;
    ni = n_imask;
    pulse(wait_instr);
    check(16'(n_imask - ni), 1);
    check(cur_mode, omc_pkg::OMC_MODE_WAIT);
    check({cpu_clk_en, cpu_run}, 0);
    check({sys_clk_en, reg_full}, 2'h3);
    for (int k = 0; k < 7; k++) begin
      if (k == 1 || k == 3) continue;
      u_host.issue(omc_pkg::omc_cmd_e'(k), acc, err);
      check(acc, 0);
    end
    u_host.issue(omc_pkg::OMC_CMD_MEM_STAT, acc, err);
    check({acc, err}, 2'h3);
    check(status_data, omc_pkg::MEM_STAT_LOWPWR);
    ns = n_stack;
    @(negedge clock);
    irq_req = 1'b1;
    step(2);
    irq_req = 1'b0;
    check(16'(n_stack - ns), 1);
    check({cur_mode, cpu_clk_en}, {omc_pkg::OMC_MODE_RUN, 1'b1});
    pulse(wait_instr);
    u_host.issue(omc_pkg::OMC_CMD_HALT, acc, err);
    check({acc, cur_mode}, {1'b1, omc_pkg::OMC_MODE_BKGD});
    u_host.issue(omc_pkg::OMC_CMD_RESUME, acc, err);
  endtask
  task automatic t_stop;
    stop_enable_option = 1'b1;
    for (int d = 1; d >= 0; d--) begin
      deep_stop_sel = d[0];
      pulse(stop_instr);
      check(cur_mode, omc_pkg::OMC_MODE_STOP);
      check({sys_clk_en, reg_full, deep_pd}, {2'h0, d[0]});
      u_host.issue(omc_pkg::OMC_CMD_MEM, acc, err);
      check(acc, 0);
      if (d == 1) begin
        u_host.issue(omc_pkg::OMC_CMD_MEM_STAT, acc, err);
        check(status_data, omc_pkg::MEM_STAT_LOWPWR);
        pulse(wake_evt);
      end else begin
        u_host.issue(omc_pkg::OMC_CMD_HALT, acc, err);
        check(cur_mode, omc_pkg::OMC_MODE_BKGD);
        u_host.issue(omc_pkg::OMC_CMD_RESUME, acc, err);
      end
      check(cur_mode, omc_pkg::OMC_MODE_RUN);
    end
    stop_enable_option = 1'b0;
    pulse(stop_instr);
    check({illegal_reset, cur_mode}, {1'b1, omc_pkg::OMC_MODE_RUN});
  endtask
  // pin held low through reset release; all commands open in background
  task automatic t_bkgd;
    do_reset(1'b1);
    step(6);
    u_host.hold_low = 1'b0;
    check(cur_mode, omc_pkg::OMC_MODE_BKGD);
    check({cpu_run, mem_rd, illegal_reset}, 0);
    for (int k = 0; k < 6; k++) begin
      u_host.issue(omc_pkg::omc_cmd_e'(k), acc, err);
      check(acc, 1);
    end
    u_host.issue(omc_pkg::OMC_CMD_RESUME, acc, err);
    check({acc, cur_mode, cpu_run}, {1'b1, omc_pkg::OMC_MODE_RUN, 1'b1});
  endtask

  initial begin
    rstn = 1'b0;
    {halt_instr, ctrl_brk, trace_brk, wait_instr, stop_instr} = 5'h0;
    {stop_enable_option, deep_stop_sel, irq_req, wake_evt, tclk_route_we} = 5'h0;
    {tclk_route_wr, tclk_in, alt1_en, alt2_en} = 15'h0;
    {port_out, alt1_out, alt2_out, mem_rdata} = 17'h0;
    {fail_count, tests_run, cycles, n_imask, n_stack} = '0;
    t_vector();
    t_timers();
    t_pins();
    t_phase();
    t_run_cmds();
    t_wait();
    t_stop();
    t_bkgd();
    tally_and_finish();
  end
endmodule
